// ### bench/icc_checker_properties.sv
// port assertions for the interrupt cause classifier
`timescale 1ns/1ps
module icc_checker (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire icc_pkg::icc_msr_t   msr,
  input wire icc_pkg::icc_async_t async_src,
  input wire icc_pkg::icc_req_t   req_ff,
  input wire logic               flush_younger_ff,
  input wire logic               save_primary_ff,
  input wire logic               save_critical_ff,
  input wire logic               save_debug_ff,
  input wire logic               sys_reset_ff
);
  import icc_pkg::*;
  // ----------------
  // checks
  // ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_crit_cause: assert property (
    req_ff.valid && req_ff.index == 5'h00 |->
    $past(!async_src.crit_req_n && msr.critical_enable_bit)) else $error("bad critical");
  a_ext_cause: assert property (
    req_ff.valid && req_ff.index == 5'h04 |->
    $past(!async_src.ext_req_n && msr.external_enable_bit)) else $error("bad external");
  a_mchk_gate: assert property (
    req_ff.valid && req_ff.index == 5'h01 |->
    $past(msr.machine_check_enable_bit) && req_ff.cls == ICC_CLS_CRIT) else $error("bad mchk");
  a_valid_pulse: assert property (req_ff.valid |=> !req_ff.valid)
    else $error("valid too long");
  a_save_class: assert property (
    save_critical_ff == (req_ff.valid && req_ff.cls == ICC_CLS_CRIT) &&
    save_primary_ff == (req_ff.valid && req_ff.cls == ICC_CLS_NONCRIT) &&
    save_debug_ff == (req_ff.valid && req_ff.cls == ICC_CLS_DEBUG)) else $error("bad save");
  a_flush_precise: assert property (
    flush_younger_ff == (req_ff.valid && req_ff.precise)) else $error("bad flush");
  a_sync_class: assert property (
    req_ff.valid && req_ff.index inside {5'h02, 5'h03, 5'h05} |->
    req_ff.sync && req_ff.precise && req_ff.cls == ICC_CLS_NONCRIT) else $error("bad sync");
  a_async_class: assert property (
    req_ff.valid && req_ff.index inside {5'h00, 5'h04, 5'h0A, 5'h0B, 5'h0C} |->
    !req_ff.sync && !req_ff.precise &&
    req_ff.cls == (req_ff.index inside {5'h00, 5'h0C} ? ICC_CLS_CRIT : ICC_CLS_NONCRIT))
    else $error("bad async");
  a_reset_src: assert property (
    !async_src.reset_pin_n || async_src.wdog_reset || async_src.debug_reset |=>
    sys_reset_ff && !req_ff.valid) else $error("bad reset");
endmodule
bind icc_classifier icc_checker u_icc_checker (.ref_clk, .rst, .msr, .async_src, .req_ff,
  .flush_younger_ff, .save_primary_ff, .save_critical_ff, .save_debug_ff, .sys_reset_ff);

// ### bench/icc_src_model.sv
// model of the interrupt sources and the fetch acknowledge
`timescale 1ns/1ps
module icc_src_model (
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic [4:0]     sel,
  input  wire logic           slow,
  input  wire logic           valid,
  output icc_pkg::icc_async_t async_src,
  output icc_pkg::icc_sync_t  sync_src,
  output logic                take_ack
);
  import icc_pkg::*;
  logic [2:0] dly_ff;
  logic [2:0] nxt_dly;
  // ----------------
  // sources
  // ----------------
  always_comb begin
    async_src = 12'hF00;
    sync_src = 17'h00000;
    nxt_dly = {dly_ff[1:0], valid};
    case (sel)
      5'h01: async_src = 12'h700;
      5'h02: async_src = 12'hB00;
      5'h03: async_src = 12'hD00;
      5'h04: sync_src = 17'h18000;
      5'h05: sync_src = 17'h02000;
      5'h06: sync_src = 17'h01C00;
      5'h07: sync_src = 17'h00200;
      5'h08: sync_src = 17'h00100;
      5'h09: sync_src = 17'h00080;
      5'h0A: sync_src = 17'h00040;
      5'h0B: sync_src = 17'h00020;
      5'h0C: sync_src = 17'h00010;
      5'h0D: sync_src = 17'h00008;
      5'h0E: sync_src = 17'h00004;
      5'h0F: sync_src = 17'h00002;
      5'h10: sync_src = 17'h00001;
      5'h11: async_src = 12'hF20;
      5'h12: async_src = 12'hF10;
      5'h13: async_src = 12'hF08;
      5'h14: async_src = 12'hF04;
      5'h15: async_src = 12'hF01;
      5'h16: sync_src = 17'h01400;
      5'h17: async_src = 12'hF02;
      5'h18: async_src = 12'hE00;
      5'h19: async_src = 12'hF80;
      5'h1A: async_src = 12'hF40;
      default: ;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dly_ff <= 3'h0;
    end else begin
      dly_ff <= nxt_dly;
    end
  end
  assign take_ack = slow ? dly_ff[2] : valid;
endmodule

// ### bench/interrupt_cause_classifier_test.sv
// self-checking bench for the interrupt cause classifier
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %0h want %0h", $time, a, b); end end
module interrupt_cause_classifier_test;
  import icc_pkg::*;
  logic        ref_clk, rst, slow, ack, sres, sup, hit;
  logic [4:0]  sel;
  icc_msr_t    msr, smsr;
  icc_async_t  asrc;
  icc_sync_t   ssrc;
  icc_req_t    req;
  logic [31:0] pfx, res, haddr, saddr;
  logic [15:0] offs [16];
  int          num_errors = 0, tests_run = 0, cyc = 0;
  icc_classifier u_icc_classifier (.ref_clk, .rst, .msr, .async_src(asrc), .sync_src(ssrc),
    .vector_prefix_reg(pfx), .vector_offset_reg(offs), .resume_addr(res), .take_ack(ack),
    .sys_reset_ff(sres), .req_ff(req), .handler_addr_ff(haddr), .flush_younger_ff(),
    .save_primary_ff(), .save_critical_ff(), .save_debug_ff(), .save_addr_ff(saddr),
    .save_msr_ff(smsr), .supervisor_ff(sup));
  icc_src_model u_icc_src_model (.ref_clk, .rst, .sel, .slow, .valid(req.valid),
    .async_src(asrc), .sync_src(ssrc), .take_ack(ack));
  // ----------------
  // expectations
  // ----------------
  function automatic logic [8:0] exp_of(int s, icc_msr_t m);
    logic [8:0] t [27] = '{9'h000, 9'h004, 9'h040, 9'h014, 9'h014, 9'h014, 9'h023, 9'h023,
      9'h023, 9'h033, 9'h033, 9'h033, 9'h033, 9'h053, 9'h053, 9'h053, 9'h063, 9'h0C4,
      9'h0B0, 9'h0A0, 9'h0F8, 9'h0FB, 9'h033, 9'h0F8, 9'h000, 9'h000, 9'h000};
    if ((s == 6 || s == 22) && !m.external_enable_bit) return 9'h014;
    return t[s];
  endfunction
  function automatic logic gate(int s, icc_msr_t m);
    case (s)
      1, 17: return m.critical_enable_bit;
      2, 18, 19: return m.external_enable_bit;
      3, 4, 5: return m.machine_check_enable_bit;
      6, 22: return m.external_enable_bit | m.machine_check_enable_bit;
      20, 21, 23: return m.debug_enable_bit;
      default: return s inside {[7:16]};
    endcase
  endfunction
  task automatic run(int s, icc_msr_t m);
    logic [8:0] w;
    w = exp_of(s, m);
    @(posedge ref_clk);
    sel <= s[4:0];
    msr <= m;
    res <= $urandom;
    slow <= 1'($urandom);
    hit = 1'b0;
    for (int i = 0; i < 6 && hit !== 1'b1; i++) begin
      @(negedge ref_clk);
      hit = req.valid;
    end
    `CHK(hit, gate(s, m))
    if (hit === 1'b1) begin
      `CHK({req.index, req.cls, req.sync, req.precise}, w)
      `CHK(haddr, {pfx[31:16], offs[w[7:4]]})
      `CHK({saddr, smsr, sup}, {res, m, 1'b1})
    end
    if (s > 23) `CHK(sres, 1'b1)
    @(posedge ref_clk);
    sel <= 5'h00;
    repeat (5) @(posedge ref_clk);
    $display("test cause %0d done", s);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h24BAFD22));
    rst = 1'b1;
    sel = 5'h00;
    slow = 1'b0;
    msr = 4'h0;
    res = 32'h0;
    pfx = $urandom;
    foreach (offs[i]) offs[i] = 16'($urandom);
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK({sres, sup, req.valid}, 3'h6)
    @(posedge ref_clk);
    rst <= 1'b0;
    run(2, 4'h0);
    run(2, 4'hF);
    run(6, 4'h2);
    run(22, 4'h0);
    run(4, 4'h0);
    for (int s = 1; s < 27; s++) run(s, 4'hF);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (60) run($urandom_range(26, 1), 4'($urandom));
    report_and_stop();
  end
endmodule

// ### pkg/icc_params.svh
// constants for the interrupt cause classifier
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH
`define ICC_IDX_CRIT      5'h00
`define ICC_IDX_MCHK      5'h01
`define ICC_IDX_DSTOR     5'h02
`define ICC_IDX_ISTOR     5'h03
`define ICC_IDX_EXT       5'h04
`define ICC_IDX_ALIGN     5'h05
`define ICC_IDX_PROG      5'h06
`define ICC_IDX_DEC       5'h0A
`define ICC_IDX_FIT       5'h0B
`define ICC_IDX_WDOG      5'h0C
`define ICC_IDX_DEBUG     5'h0F
`define ICC_IDX_RESET     5'h00
`define ICC_PREFIX_LSB    16
`endif

// ### pkg/icc_pkg.sv
// types for the interrupt cause classifier
package icc_pkg;
  typedef enum logic [1:0] {
    ICC_CLS_NONCRIT = 2'h0,
    ICC_CLS_CRIT    = 2'h1,
    ICC_CLS_DEBUG   = 2'h2
  } icc_class_t;

  typedef struct packed {
    logic critical_enable_bit;
    logic external_enable_bit;
    logic machine_check_enable_bit;
    logic debug_enable_bit;
  } icc_msr_t;

  typedef struct packed {
    logic crit_req_n;
    logic ext_req_n;
    logic mchk_req_n;
    logic reset_pin_n;
    logic wdog_reset;
    logic debug_reset;
    logic wdog_int;
    logic fit_int;
    logic dec_int;
    logic unconditional_debug_event;
    logic debug_imprecise;
    logic debug_instr;
  } icc_async_t;

  typedef struct packed {
    logic handler_first_fetch;
    logic i_storage_fault;
    logic i_translation_fault;
    logic buffered_write_berr;
    logic transfer_error_termination;
    logic tea_data_side;
    logic tea_precise;
    logic d_access_violation;
    logic d_misalign_endian_mismatch;
    logic i_access_violation;
    logic i_vle_mismatch;
    logic i_vle_little_endian;
    logic i_odd_halfword_fixed;
    logic lmw_misaligned;
    logic resv_misaligned;
    logic zero_block_no_cache;
    logic prog_fault;
  } icc_sync_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] index;
    icc_class_t cls;
    logic       sync;
    logic       precise;
  } icc_req_t;
endpackage

// ### rtl/icc_classifier.sv
// interrupt cause recognition and classification
`timescale 1ns/1ps
`include "icc_params.svh"

module icc_classifier #(
  parameter int ADDR_W = 32
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire icc_pkg::icc_msr_t        msr,
  input  wire icc_pkg::icc_async_t      async_src,
  input  wire icc_pkg::icc_sync_t       sync_src,
  input  wire logic [ADDR_W-1:0]        vector_prefix_reg,
  input  wire logic [15:0]              vector_offset_reg [16],
  input  wire logic [ADDR_W-1:0]        resume_addr,
  input  wire logic                     take_ack,
  output logic                          sys_reset_ff,
  output icc_pkg::icc_req_t             req_ff,
  output logic [ADDR_W-1:0]             handler_addr_ff,
  output logic                          flush_younger_ff,
  output logic                          save_primary_ff,
  output logic                          save_critical_ff,
  output logic                          save_debug_ff,
  output logic [ADDR_W-1:0]             save_addr_ff,
  output icc_pkg::icc_msr_t             save_msr_ff,
  output logic                          supervisor_ff
);
  import icc_pkg::*;

  // refuse address widths below 17, which the prefix slice cannot serve, and above 64
  if (ADDR_W < 17 || ADDR_W > 64) begin : g_addr_w_check
    $error("icc_classifier: ADDR_W out of range");
  end

  // ----------------------------------------
  // cause evaluation
  // ----------------------------------------
  function automatic icc_req_t mk(input logic [4:0] idx, input icc_class_t c,
                                  input logic s, input logic p);
    icc_req_t r;
    r.valid   = 1'b1;
    r.index   = idx;
    r.cls     = c;
    r.sync    = s;
    r.precise = p;
    return r;
  endfunction

  logic     mchk_hit;
  logic     dstor_hit;
  logic     istor_hit;
  logic     align_hit;
  logic     reset_hit;
  icc_req_t sel;

  always_comb begin
    reset_hit = ~async_src.reset_pin_n | async_src.wdog_reset
              | async_src.debug_reset;
    mchk_hit = msr.machine_check_enable_bit & (
                 ~async_src.mchk_req_n
               | (sync_src.handler_first_fetch
                  & (sync_src.i_storage_fault | sync_src.i_translation_fault))
               | sync_src.buffered_write_berr
               | (sync_src.transfer_error_termination
                  & ~msr.external_enable_bit));
    dstor_hit = sync_src.d_access_violation | sync_src.d_misalign_endian_mismatch
              | (sync_src.transfer_error_termination & sync_src.tea_data_side
                 & sync_src.tea_precise & msr.external_enable_bit);
    istor_hit = ~sync_src.handler_first_fetch & (
                  sync_src.i_access_violation
                | (sync_src.transfer_error_termination & ~sync_src.tea_data_side
                   & sync_src.tea_precise & msr.external_enable_bit)
                | sync_src.i_vle_mismatch | sync_src.i_vle_little_endian
                | sync_src.i_odd_halfword_fixed);
    align_hit = sync_src.lmw_misaligned | sync_src.resv_misaligned
              | sync_src.zero_block_no_cache;
    sel = '0;
    if (mchk_hit) begin
      sel = mk(`ICC_IDX_MCHK, ICC_CLS_CRIT, 1'b0, 1'b0);
    end else if (~async_src.crit_req_n & msr.critical_enable_bit) begin
      sel = mk(`ICC_IDX_CRIT, ICC_CLS_CRIT, 1'b0, 1'b0);
    end else if (async_src.wdog_int & msr.critical_enable_bit) begin
      sel = mk(`ICC_IDX_WDOG, ICC_CLS_CRIT, 1'b0, 1'b0);
    end else if (async_src.debug_instr & msr.debug_enable_bit) begin
      sel = mk(`ICC_IDX_DEBUG, ICC_CLS_DEBUG, 1'b1, 1'b1);
    end else if ((async_src.unconditional_debug_event | async_src.debug_imprecise)
                 & msr.debug_enable_bit) begin
      sel = mk(`ICC_IDX_DEBUG, ICC_CLS_DEBUG, 1'b0, 1'b0);
    end else if (istor_hit) begin
      sel = mk(`ICC_IDX_ISTOR, ICC_CLS_NONCRIT, 1'b1, 1'b1);
    end else if (sync_src.prog_fault) begin
      sel = mk(`ICC_IDX_PROG, ICC_CLS_NONCRIT, 1'b1, 1'b1);
    end else if (align_hit) begin
      sel = mk(`ICC_IDX_ALIGN, ICC_CLS_NONCRIT, 1'b1, 1'b1);
    end else if (dstor_hit) begin
      sel = mk(`ICC_IDX_DSTOR, ICC_CLS_NONCRIT, 1'b1, 1'b1);
    end else if (~async_src.ext_req_n & msr.external_enable_bit) begin
      sel = mk(`ICC_IDX_EXT, ICC_CLS_NONCRIT, 1'b0, 1'b0);
    end else if (async_src.fit_int & msr.external_enable_bit) begin
      sel = mk(`ICC_IDX_FIT, ICC_CLS_NONCRIT, 1'b0, 1'b0);
    end else if (async_src.dec_int & msr.external_enable_bit) begin
      sel = mk(`ICC_IDX_DEC, ICC_CLS_NONCRIT, 1'b0, 1'b0);
    end
  end

  // ----------------------------------------
  // request and save registers
  // ----------------------------------------
  logic              busy_ff;
  logic              nxt_busy;
  logic              nxt_sys_reset;
  icc_req_t          nxt_req;
  logic [ADDR_W-1:0] nxt_handler_addr;
  logic              nxt_flush;
  logic              nxt_save_p;
  logic              nxt_save_c;
  logic              nxt_save_d;
  logic [ADDR_W-1:0] nxt_save_addr;
  icc_msr_t          nxt_save_msr;
  logic              nxt_super;

  always_comb begin
    nxt_sys_reset    = reset_hit;
    nxt_busy         = busy_ff & ~take_ack;
    nxt_req          = '0;
    nxt_handler_addr = handler_addr_ff;
    nxt_flush        = 1'b0;
    nxt_save_p       = 1'b0;
    nxt_save_c       = 1'b0;
    nxt_save_d       = 1'b0;
    nxt_save_addr    = save_addr_ff;
    nxt_save_msr     = save_msr_ff;
    nxt_super        = supervisor_ff;
    if (reset_hit) begin
      nxt_busy = 1'b0;
    end else if (sel.valid && !busy_ff) begin
      nxt_req          = sel;
      nxt_busy         = 1'b1;
      nxt_handler_addr = {vector_prefix_reg[ADDR_W-1:`ICC_PREFIX_LSB],
                          vector_offset_reg[sel.index[3:0]]};
      nxt_flush        = sel.precise;
      nxt_save_p       = (sel.cls == ICC_CLS_NONCRIT);
      nxt_save_c       = (sel.cls == ICC_CLS_CRIT);
      nxt_save_d       = (sel.cls == ICC_CLS_DEBUG);
      nxt_save_addr    = resume_addr;
      nxt_save_msr     = msr;
      nxt_super        = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_ff          <= 1'b0;
      sys_reset_ff     <= 1'b1;
      req_ff           <= '0;
      handler_addr_ff  <= '0;
      flush_younger_ff <= 1'b0;
      save_primary_ff  <= 1'b0;
      save_critical_ff <= 1'b0;
      save_debug_ff    <= 1'b0;
      save_addr_ff     <= '0;
      save_msr_ff      <= '0;
      supervisor_ff    <= 1'b1;
    end else begin
      busy_ff          <= nxt_busy;
      sys_reset_ff     <= nxt_sys_reset;
      req_ff           <= nxt_req;
      handler_addr_ff  <= nxt_handler_addr;
      flush_younger_ff <= nxt_flush;
      save_primary_ff  <= nxt_save_p;
      save_critical_ff <= nxt_save_c;
      save_debug_ff    <= nxt_save_d;
      save_addr_ff     <= nxt_save_addr;
      save_msr_ff      <= nxt_save_msr;
      supervisor_ff    <= nxt_super;
    end
  end
endmodule
